// *** alarm_pkg.sv ***
// Package with constants, encodings and register map of the alarm evaluator
package alarm_pkg;
    localparam int VALUE_W = 16;
    localparam int NCH = 2;
    typedef logic signed [VALUE_W-1:0] value_t;
    typedef logic [1:0] action_t;
    typedef logic [2:0] compare_t;
    localparam action_t ACT_OFF = 2'h0;
    localparam action_t ACT_FOLLOW = 2'h1;
    localparam action_t ACT_LATCH = 2'h2;
    localparam action_t ACT_EVENT = 2'h3;
    localparam compare_t CMP_PROC_LOW = 3'h0;
    localparam compare_t CMP_PROC_HIGH = 3'h1;
    localparam compare_t CMP_BAND_INV = 3'h2;
    localparam compare_t CMP_BAND_NORM = 3'h3;
    localparam compare_t CMP_OFFSET_BELOW = 3'h4;
    localparam compare_t CMP_OFFSET_ABOVE = 3'h5;
    // Word addresses; the action and operation words use the host codes
    localparam logic [7:0] ADDR_FIRST_ACTION = 8'hC2;
    localparam logic [7:0] ADDR_FIRST_COMPARE = 8'hC3;
    localparam logic [7:0] ADDR_FIRST_THRESH = 8'hC6;
    localparam logic [7:0] ADDR_SECOND_ACTION = 8'hC8;
    localparam logic [7:0] ADDR_SECOND_COMPARE = 8'hC9;
    localparam logic [7:0] ADDR_SECOND_THRESH = 8'hD2;
    localparam logic [7:0] ADDR_STATUS = 8'hE0;
    localparam logic [7:0] ADDR_INT_STAT = 8'hE1;
    localparam logic [7:0] ADDR_INT_MASK = 8'hE2;
    localparam int ADDR_LSB = 2;
    localparam action_t RST_ACTION = ACT_OFF;
    localparam compare_t RST_FIRST_COMPARE = CMP_PROC_HIGH;
    localparam compare_t RST_SECOND_COMPARE = CMP_PROC_LOW;
    localparam value_t RST_THRESH = 16'h0000;
endpackage : alarm_pkg

// *** alarm_compare.sv ***
// Per-channel comparison of process value against threshold or setpoint
`timescale 1ns/1ps
module alarm_compare (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Operands
    input wire logic sample_valid,
    input wire alarm_pkg::value_t process_value,
    input wire alarm_pkg::value_t process_setpoint,
    input wire alarm_pkg::value_t threshold,
    input wire alarm_pkg::compare_t compare_sel,
    // Result, registered
    output logic cond_q
);
    import alarm_pkg::*;
    logic signed [VALUE_W:0] diff;
    logic signed [VALUE_W:0] adiff;
    logic signed [VALUE_W:0] thr_x;
    logic cond_d;

    // One extra bit so the deviation never wraps
    always_comb begin
        diff = {process_value[VALUE_W-1], process_value}
            - {process_setpoint[VALUE_W-1], process_setpoint};
        adiff = diff[VALUE_W] ? -diff : diff;
        thr_x = {threshold[VALUE_W-1], threshold};
        cond_d = 1'b0;
        unique case (compare_sel)
            CMP_PROC_HIGH: cond_d = process_value >= threshold;
            CMP_PROC_LOW: cond_d = process_value <= threshold;
            CMP_OFFSET_ABOVE: cond_d = diff >= thr_x;
            CMP_OFFSET_BELOW: cond_d = -diff >= thr_x;
            CMP_BAND_INV: cond_d = adiff <= thr_x;
            CMP_BAND_NORM: cond_d = adiff >= thr_x;
            default: cond_d = 1'b0;
        endcase
    end

    // Result only moves on a new sample
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cond_q <= 1'b0;
        end else if (sample_valid) begin
            cond_q <= cond_d;
        end
    end
endmodule : alarm_compare

// *** process_alarm_evaluator.sv ***
// Two-channel process alarm evaluator with Wishbone registers
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
module process_alarm_evaluator (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Measurement path, same clock
    input wire logic sample_valid,
    input wire alarm_pkg::value_t process_value,
    input wire alarm_pkg::value_t process_setpoint,
    // Operator key pin and recipe events
    input wire logic ack_key,
    input wire logic [1:0] recipe_event,
    // Indicators and outputs
    output logic [1:0] alarm_led_q,
    output logic [1:0] alarm_out_q,
    output logic irq_q
);
    import alarm_pkg::*;

    action_t action_q [NCH];
    compare_t compare_q [NCH];
    value_t thresh_q [NCH];
    logic [NCH-1:0] cond;
    logic [NCH-1:0] active_d;
    logic [NCH-1:0] latch_q;
    logic [NCH-1:0] int_stat_q;
    logic [NCH-1:0] int_mask_q;
    logic [NCH-1:0] led_prev_q;
    logic key_meta_q;
    logic key_sync_q;
    logic key_prev_q;
    logic ack_pulse;
    logic wb_req;
    logic wb_wr;
    logic [7:0] word;
    logic low_lane;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i;
    assign word = wb_adr_i[ADDR_LSB +: 8];
    assign low_lane = wb_sel_i[0];

    // Key is asynchronous; first stage read only by the second
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            key_meta_q <= 1'b0;
            key_sync_q <= 1'b0;
            key_prev_q <= 1'b0;
        end else begin
            key_meta_q <= ack_key;
            key_sync_q <= key_meta_q;
            key_prev_q <= key_sync_q;
        end
    end
    assign ack_pulse = key_sync_q && !key_prev_q;

    // Configuration registers, one set per channel
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            localparam logic [7:0] A_ACT =
                (g == 0) ? ADDR_FIRST_ACTION : ADDR_SECOND_ACTION;
            localparam logic [7:0] A_CMP =
                (g == 0) ? ADDR_FIRST_COMPARE : ADDR_SECOND_COMPARE;
            localparam logic [7:0] A_THR =
                (g == 0) ? ADDR_FIRST_THRESH : ADDR_SECOND_THRESH;
            localparam compare_t RST_CMP =
                (g == 0) ? RST_FIRST_COMPARE : RST_SECOND_COMPARE;

            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    action_q[g] <= RST_ACTION;
                    compare_q[g] <= RST_CMP;
                    thresh_q[g] <= RST_THRESH;
                end else if (wb_wr) begin
                    if (word == A_ACT && low_lane) begin
                        action_q[g] <= wb_dat_i[1:0];
                    end
                    if (word == A_CMP && low_lane) begin
                        compare_q[g] <= wb_dat_i[2:0];
                    end
                    if (word == A_THR) begin
                        if (wb_sel_i[0]) begin
                            thresh_q[g][7:0] <= wb_dat_i[7:0];
                        end
                        if (wb_sel_i[1]) begin
                            thresh_q[g][15:8] <= wb_dat_i[15:8];
                        end
                    end
                end
            end

            alarm_compare u_cmp (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .sample_valid(sample_valid),
                .process_value(process_value),
                .process_setpoint(process_setpoint),
                .threshold(thresh_q[g]),
                .compare_sel(compare_q[g]),
                .cond_q(cond[g])
            );

            // Latch clears on acknowledge with the condition gone, or whenever the action is not latch
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    latch_q[g] <= 1'b0;
                end else if (action_q[g] != ACT_LATCH) begin
                    latch_q[g] <= 1'b0;
                end else if (cond[g]) begin
                    latch_q[g] <= 1'b1;
                end else if (ack_pulse) begin
                    latch_q[g] <= 1'b0;
                end
            end

            always_comb begin
                active_d[g] = 1'b0;
                unique case (action_q[g])
                    ACT_OFF: active_d[g] = 1'b0;
                    ACT_FOLLOW: active_d[g] = cond[g];
                    ACT_LATCH: active_d[g] = cond[g] || latch_q[g];
                    ACT_EVENT: active_d[g] = recipe_event[g];
                endcase
            end

            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    alarm_led_q[g] <= 1'b0;
                    alarm_out_q[g] <= 1'b0;
                end else begin
                    alarm_led_q[g] <= active_d[g];
                    alarm_out_q[g] <= active_d[g];
                end
            end
        end
    endgenerate

    // Sticky rise events; a new event wins over a write-one clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            led_prev_q <= '0;
            int_stat_q <= '0;
            int_mask_q <= '0;
        end else begin
            led_prev_q <= alarm_led_q;
            if (wb_wr && word == ADDR_INT_MASK && low_lane) begin
                int_mask_q <= wb_dat_i[NCH-1:0];
            end
            if (wb_wr && word == ADDR_INT_STAT && low_lane) begin
                int_stat_q <= (int_stat_q & ~wb_dat_i[NCH-1:0])
                    | (alarm_led_q & ~led_prev_q);
            end else begin
                int_stat_q <= int_stat_q | (alarm_led_q & ~led_prev_q);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(int_stat_q & int_mask_q);
        end
    end

    // One-wait-state slave; unmapped words read zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                unique case (word)
                    ADDR_FIRST_ACTION: wb_dat_o[1:0] <= action_q[0];
                    ADDR_SECOND_ACTION: wb_dat_o[1:0] <= action_q[1];
                    ADDR_FIRST_COMPARE: wb_dat_o[2:0] <= compare_q[0];
                    ADDR_SECOND_COMPARE: wb_dat_o[2:0] <= compare_q[1];
                    ADDR_FIRST_THRESH: wb_dat_o[15:0] <= thresh_q[0];
                    ADDR_SECOND_THRESH: wb_dat_o[15:0] <= thresh_q[1];
                    ADDR_STATUS: wb_dat_o[3:0] <= {cond, alarm_led_q};
                    ADDR_INT_STAT: wb_dat_o[1:0] <= int_stat_q;
                    ADDR_INT_MASK: wb_dat_o[1:0] <= int_mask_q;
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Checks
    sequence s_latched(int c);
        latch_q[c] && action_q[c] == ACT_LATCH && !cond[c];
    endsequence

    // Key seen high on two edges in a row
    sequence s_key_held;
        key_sync_q ##1 key_sync_q;
    endsequence

    property p_off_quiet;
        @(posedge sys_clk) disable iff (sys_rst)
        action_q[0] == ACT_OFF && $past(action_q[0]) == ACT_OFF
            |-> !alarm_led_q[0];
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("off lit");

    property p_follow;
        @(posedge sys_clk) disable iff (sys_rst)
        action_q[1] == ACT_FOLLOW ##1 action_q[1] == ACT_FOLLOW
            |-> alarm_led_q[1] == $past(cond[1]);
    endproperty
    a_follow: assert property (p_follow) else $error("follow bad");

    property p_latch_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        s_latched(0) ##0 !ack_pulse |=> alarm_led_q[0];
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch dropped");

    property p_out_tracks;
        @(posedge sys_clk) disable iff (sys_rst)
        alarm_out_q == alarm_led_q;
    endproperty
    a_out_tracks: assert property (p_out_tracks)
        else $error("output differs");

    property p_event;
        @(posedge sys_clk) disable iff (sys_rst)
        action_q[1] == ACT_EVENT |=> alarm_led_q[1] == $past(recipe_event[1]);
    endproperty
    a_event: assert property (p_event) else $error("event bad");

    property p_ack_clear;
        @(posedge sys_clk) disable iff (sys_rst)
        latch_q[0] && ack_pulse && !cond[0] && action_q[0] == ACT_LATCH
            && !wb_wr |=> !latch_q[0];
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("ack ignored");

    property p_ack_keep;
        @(posedge sys_clk) disable iff (sys_rst)
        latch_q[0] && cond[0] && action_q[0] == ACT_LATCH && !wb_wr
            |=> latch_q[0];
    endproperty
    a_ack_keep: assert property (p_ack_keep)
        else $error("latch lost");

    property p_wb_ack;
        @(posedge sys_clk) disable iff (sys_rst)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("ack timing");

    // A held key must not give a second acknowledge
    property p_ack_single;
        @(posedge sys_clk) disable iff (sys_rst)
        s_key_held |-> !ack_pulse;
    endproperty
    a_ack_single: assert property (p_ack_single)
        else $error("ack repeated");

    property p_off_quiet_b;
        @(posedge sys_clk) disable iff (sys_rst)
        action_q[1] == ACT_OFF && $past(action_q[1]) == ACT_OFF
            |-> !alarm_led_q[1] && !alarm_out_q[1];
    endproperty
    a_off_quiet_b: assert property (p_off_quiet_b)
        else $error("off lit");

    property p_latch_set;
        @(posedge sys_clk) disable iff (sys_rst)
        action_q[0] == ACT_LATCH && cond[0]
            |=> alarm_led_q[0] && latch_q[0];
    endproperty
    a_latch_set: assert property (p_latch_set)
        else $error("latch not set");
endmodule : process_alarm_evaluator

// *** alarm_partner.sv ***
// Model of the operator panel, measurement path and recipe sequencer
`timescale 1ns/1ps
module alarm_partner (
    // Clock
    input wire logic sys_clk,
    // Measurement path
    output logic sample_valid,
    output alarm_pkg::value_t process_value,
    output alarm_pkg::value_t process_setpoint,
    // Operator key and recipe events
    output logic ack_key,
    output logic [1:0] recipe_event
);
    import alarm_pkg::*;

    initial begin
        sample_valid = 1'b0;
        process_value = 16'h0000;
        process_setpoint = 16'h0000;
        ack_key = 1'b0;
        recipe_event = 2'b00;
    end

    // One valid cycle per sample; data is scrambled afterwards so that
    // a design reading it outside the valid cycle is caught
    task automatic sample(input value_t pv, input value_t sp);
        @(posedge sys_clk);
        sample_valid <= 1'b1;
        process_value <= pv;
        process_setpoint <= sp;
        @(posedge sys_clk);
        sample_valid <= 1'b0;
        process_value <= ~pv;
        process_setpoint <= ~sp;
    endtask : sample

    // Key held several cycles; the design must make one pulse of it
    task automatic press();
        @(posedge sys_clk);
        ack_key <= 1'b1;
        repeat (4) @(posedge sys_clk);
        ack_key <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask : press

    task automatic set_event(input logic [1:0] e);
        @(posedge sys_clk);
        recipe_event <= e;
    endtask : set_event
endmodule : alarm_partner

// *** tb_top.sv ***
// Self-checking bench for the two-channel process alarm evaluator
`timescale 1ns/1ps
module tb_top;
    import alarm_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic sample_valid;
    value_t process_value;
    value_t process_setpoint;
    logic ack_key;
    logic [1:0] recipe_event;
    logic [1:0] alarm_led_q;
    logic [1:0] alarm_out_q;
    logic irq_q;
    logic [31:0] rd;
    int fail_count = 0;
    int n_checks = 0;

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    process_alarm_evaluator DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sample_valid(sample_valid), .process_value(process_value),
        .process_setpoint(process_setpoint), .ack_key(ack_key),
        .recipe_event(recipe_event), .alarm_led_q(alarm_led_q),
        .alarm_out_q(alarm_out_q), .irq_q(irq_q));

    alarm_partner panel (.sys_clk(sys_clk), .sample_valid(sample_valid),
        .process_value(process_value), .process_setpoint(process_setpoint),
        .ack_key(ack_key), .recipe_event(recipe_event));

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk

    // Classic single cycle; waits for ack without assuming a latency
    task automatic wb(input logic [7:0] a, input logic we,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {a, 2'b00};
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) fail_count++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge sys_clk);
    endtask : wb

    task automatic settle();
        repeat (3) @(posedge sys_clk);
    endtask : settle

    // Channel 0: set operation and value, feed one sample, check both pins
    task automatic one_case(input compare_t c, input value_t thr,
                            input value_t pv, input value_t sp,
                            input logic e);
        wb(ADDR_FIRST_COMPARE, 1'b1, {29'h0, c});
        wb(ADDR_FIRST_THRESH, 1'b1, {16'h0000, thr});
        panel.sample(pv, sp);
        settle();
        chk({alarm_out_q[0], alarm_led_q[0]}, {e, e});
    endtask : one_case

    initial begin
        #200_000;
        fail_count++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wb(ADDR_FIRST_ACTION, 1'b0, 32'h0000_0000);
        chk(rd, {30'h0, ACT_OFF});
        wb(ADDR_SECOND_ACTION, 1'b0, 32'h0000_0000);
        chk(rd, {30'h0, ACT_OFF});
        wb(ADDR_FIRST_COMPARE, 1'b0, 32'h0000_0000);
        chk(rd, {29'h0, CMP_PROC_HIGH});
        wb(ADDR_SECOND_COMPARE, 1'b0, 32'h0000_0000);
        chk(rd, {29'h0, CMP_PROC_LOW});
        wb(8'h10, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // First channel's condition true but both channels off
        panel.sample(100, 0);
        settle();
        chk({alarm_out_q, alarm_led_q, irq_q}, 5'h00);
        wb(ADDR_FIRST_ACTION, 1'b1, {30'h0, ACT_FOLLOW});
        one_case(CMP_PROC_HIGH, 200, 200, -300, 1'b1);
        one_case(CMP_PROC_HIGH, 200, 199, 0, 1'b0);
        one_case(CMP_PROC_LOW, -50, -50, 0, 1'b1);
        one_case(CMP_PROC_LOW, -50, -49, 0, 1'b0);
        one_case(CMP_OFFSET_ABOVE, 50, 150, 100, 1'b1);
        one_case(CMP_OFFSET_ABOVE, 50, 149, 100, 1'b0);
        one_case(CMP_OFFSET_BELOW, 50, 50, 100, 1'b1);
        one_case(CMP_OFFSET_BELOW, 50, 51, 100, 1'b0);
        one_case(CMP_BAND_INV, 10, -110, -100, 1'b1);
        one_case(CMP_BAND_INV, 10, -89, -100, 1'b0);
        one_case(CMP_BAND_NORM, 10, 90, 100, 1'b1);
        one_case(CMP_BAND_NORM, 10, 91, 100, 1'b0);
        one_case(CMP_OFFSET_ABOVE, 32767, 32767, -32768, 1'b1);
        // Second channel alone raises its own indicator
        wb(ADDR_SECOND_ACTION, 1'b1, {30'h0, ACT_FOLLOW});
        panel.sample(-5, 0);
        settle();
        chk({alarm_out_q, alarm_led_q}, 4'hA);
        wb(ADDR_SECOND_ACTION, 1'b1, {30'h0, ACT_OFF});
        wb(ADDR_INT_STAT, 1'b1, 32'h0000_0003);
        wb(ADDR_FIRST_COMPARE, 1'b1, {29'h0, CMP_PROC_HIGH});
        wb(ADDR_FIRST_THRESH, 1'b1, 32'h0000_000A);
        wb(ADDR_FIRST_ACTION, 1'b1, {30'h0, ACT_LATCH});
        panel.sample(20, 0);
        settle();
        chk({alarm_out_q, alarm_led_q, irq_q}, 5'h0A);
        wb(ADDR_INT_STAT, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        wb(ADDR_STATUS, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0005);
        wb(ADDR_FIRST_THRESH, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_000A);
        // Acknowledge while the condition is still present
        panel.press();
        chk({alarm_out_q[0], alarm_led_q[0]}, 2'b11);
        panel.sample(0, 0);
        settle();
        chk({alarm_out_q[0], alarm_led_q[0]}, 2'b11);
        panel.press();
        chk({alarm_out_q[0], alarm_led_q[0]}, 2'b00);
        wb(ADDR_INT_MASK, 1'b1, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk(irq_q, 1'b1);
        wb(ADDR_INT_STAT, 1'b1, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk(irq_q, 1'b0);
        // Channel 0 off so its latch cannot light during the event test
        wb(ADDR_FIRST_ACTION, 1'b1, {30'h0, ACT_OFF});
        // Event action: comparison true but only recipe events count
        wb(ADDR_SECOND_COMPARE, 1'b1, {29'h0, CMP_PROC_HIGH});
        wb(ADDR_SECOND_THRESH, 1'b1, 32'h0000_0000);
        wb(ADDR_SECOND_ACTION, 1'b1, {30'h0, ACT_EVENT});
        panel.sample(100, 0);
        settle();
        chk({alarm_out_q[1], alarm_led_q[1]}, 2'b00);
        panel.set_event(2'b10);
        settle();
        chk({alarm_out_q, alarm_led_q}, 4'hA);
        panel.set_event(2'b00);
        settle();
        chk({alarm_out_q, alarm_led_q}, 4'h0);
        wb(ADDR_SECOND_ACTION, 1'b0, 32'h0000_0000);
        chk(rd, {30'h0, ACT_EVENT});
        close_out();
    end
endmodule : tb_top
